// ### include/timer_defines.svh
// constants for the periodic timer capture block
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// counter and compare widths
`define CNT_W          10
`define CNT_ZERO       10'h000
`define CNT_ONE        10'h001
`define CNT_MAX        10'h3ff

// source field width, four primary pin choices
`define SRC_W          2
`define SRC_N          4

// delays in timer clock periods (the flag delay also in half periods), timer clock is clk_sys (5 ns)
`define FLAG_DELAY_HALF_PERIODS  1
`define FLAG_DELAY_CYCLES        ((`FLAG_DELAY_HALF_PERIODS + 1) / 2)
`define PULSE_MIN_PERIODS        2

`endif

// ### include/timer_pkg.sv
// types shared by the periodic timer capture block
package timer_pkg;
	`include "timer_defines.svh"

	// operating mode field
	typedef enum logic [1:0] {
		MODE_COMPARE = 2'h0,
		MODE_CAPTURE = 2'h1,
		MODE_PWM     = 2'h2,
		MODE_TIMER   = 2'h3
	} op_mode_t;

	// edge / output control field, capture meaning
	typedef enum logic [1:0] {
		EDGE_RISE = 2'h0,
		EDGE_FALL = 2'h1,
		EDGE_BOTH = 2'h2,
		EDGE_NONE = 2'h3
	} edge_sel_t;

	// counter clear selection field
	typedef enum logic [1:0] {
		CLR_PERIOD = 2'h0,
		CLR_RISE   = 2'h1,
		CLR_FALL   = 2'h2,
		CLR_BOTH   = 2'h3
	} clear_sel_t;

	// software control bits
	typedef struct packed {
		op_mode_t               opMode;
		edge_sel_t              edgeOutputCtrl;
		clear_sel_t             captureClearSel;
		logic [`SRC_W-1:0]      inputSourceField;
		logic                   captureSourceSelect;
		logic                   compareClearSelect;
		logic                   outputInitialState;
		logic                   outputPolarity;
		logic [`CNT_W-1:0]      periodCompareValue;
	} ctrl_t;

	// one capture write toward the store
	typedef struct packed {
		logic                   wrEn;
		logic                   toB;
		logic [`CNT_W-1:0]      value;
	} cap_wr_t;

	// interrupt flags and level flag
	typedef struct packed {
		logic                   compareAIrqFlag;
		logic                   periodIrqFlag;
		logic                   captureLevelFlag;
	} flags_t;

	// state of the timer core
	typedef struct packed {
		logic [`CNT_W-1:0]      cnt;
		logic                   run;
		logic                   flagPend;
		logic                   levelPend;
		logic                   pulseOut;
		flags_t                 flags;
	} tmr_state_t;
endpackage : timer_pkg

// ### logic/edge_detect.sv
// edge detector for the capture input; combinational edges from a registered previous level
`timescale 1ns/1ps
module edge_detect (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	// sampled pin and its edges
	input  wire logic pinIn,
	output logic      rise,
	output logic      fall
);
	typedef struct packed {
		logic prev;
	} edge_state_t;

	edge_state_t stQ;
	edge_state_t stD;

	// previous level only; edges are combinational so the latch lands one clock later
	always_comb begin
		stD      = stQ;
		stD.prev = pinIn;
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			stQ <= '0;
		end else begin
			stQ <= stD;
		end
	end

	assign rise = pinIn & ~stQ.prev;
	assign fall = ~pinIn & stQ.prev;
endmodule : edge_detect

// ### logic/capture_store.sv
// two capture registers with registered read data
`timescale 1ns/1ps
`include "timer_defines.svh"
module capture_store
	import timer_pkg::*;
(
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                sys_rst,
	// write side
	input  timer_pkg::cap_wr_t       capWr,
	// held values
	output logic [`CNT_W-1:0]        captureCompareAValue,
	output logic [`CNT_W-1:0]        captureBValue
);
	typedef struct packed {
		logic [`CNT_W-1:0] regA;
		logic [`CNT_W-1:0] regB;
	} store_state_t;

	store_state_t stQ;
	store_state_t stD;

	// one write per clock, steered by the select bit
	always_comb begin
		stD = stQ;
		if (capWr.wrEn && capWr.toB) begin
			stD.regB = capWr.value;
		end else if (capWr.wrEn) begin
			stD.regA = capWr.value;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			stQ <= '0;
		end else begin
			stQ <= stD;
		end
	end

	assign captureCompareAValue = stQ.regA;
	assign captureBValue        = stQ.regB;
endmodule : capture_store

// ### logic/periodic_timer_capture_pulse.sv
// periodic timer: capture input operation and single pulse start
`timescale 1ns/1ps
`include "timer_defines.svh"
module periodic_timer_capture_pulse (
	// clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   sys_rst,
	// software control bits
	input  timer_pkg::ctrl_t            ctrl,
	input  wire logic                   runWrEn,
	input  wire logic                   runWrData,
	input  wire logic                   compareAFlagClr,
	input  wire logic                   periodFlagClr,
	// capture pins
	input  wire logic [`SRC_N-1:0]      primaryCapturePin,
	input  wire logic                   extClockPin,
	// status
	output logic                        timerRunBit,
	output logic [`CNT_W-1:0]           counterValue,
	output timer_pkg::flags_t           flags,
	output logic                        timerIrq,
	// capture values
	output logic [`CNT_W-1:0]           captureCompareAValue,
	output logic [`CNT_W-1:0]           captureBValue,
	// timer output pin
	output logic                        timerOut
);
	import timer_pkg::*;

	tmr_state_t         stQ;
	tmr_state_t         stD;
	cap_wr_t            capWr;
	logic               srcPin;
	logic               riseEv;
	logic               fallEv;
	logic               extRise;
	logic               captureMode;
	logic               singlePulse;
	logic               edgeHit;
	logic               latchStrobe;
	logic               edgeClr;
	logic               periodMatch;
	logic               runNext;

	// capture source; the external pin must not also be the clock source
	assign srcPin = ctrl.captureSourceSelect ? extClockPin
		: primaryCapturePin[ctrl.inputSourceField];

	// edge detector on the chosen source
	edge_detect uSrcEdge (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.pinIn   (srcPin),
		.rise    (riseEv),
		.fall    (fallEv)
	);

	// separate detector on the external pin for single pulse start
	edge_detect uExtEdge (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.pinIn   (extClockPin),
		.rise    (extRise),
		.fall    ()
	);

	// mode decode
	assign captureMode = (ctrl.opMode == MODE_CAPTURE);
	assign singlePulse = (ctrl.opMode == MODE_PWM) && (ctrl.edgeOutputCtrl == EDGE_NONE);

	// active capture edge; no glitch filter, so short pulses are still caught
	always_comb begin
		unique case (ctrl.edgeOutputCtrl)
			EDGE_RISE: edgeHit = riseEv;
			EDGE_FALL: edgeHit = fallEv;
			EDGE_BOTH: edgeHit = riseEv | fallEv;
			EDGE_NONE: edgeHit = 1'b0;
		endcase
	end

	assign latchStrobe = captureMode && stQ.run && edgeHit;

	// edge clears follow the clear field, independent of the edge field
	always_comb begin
		unique case (ctrl.captureClearSel)
			CLR_PERIOD: edgeClr = 1'b0;
			CLR_RISE:   edgeClr = riseEv;
			CLR_FALL:   edgeClr = fallEv;
			CLR_BOTH:   edgeClr = riseEv | fallEv;
		endcase
	end

	// period zero lets the counter reach its maximum before wrapping
	assign periodMatch = (ctrl.periodCompareValue == `CNT_ZERO)
		? (stQ.cnt == `CNT_MAX)
		: (stQ.cnt == ctrl.periodCompareValue);

	// software write or external start in single pulse
	always_comb begin
		runNext = stQ.run;
		if (runWrEn) begin
			runNext = runWrData;
		end
		if (singlePulse && extRise) begin
			runNext = 1'b1;
		end
	end

	// capture write: clear field 00 always stores into A, otherwise a
	// falling edge goes to B and a rising edge to A
	always_comb begin
		capWr.wrEn  = latchStrobe;
		capWr.value = stQ.cnt;
		capWr.toB   = (ctrl.captureClearSel != CLR_PERIOD) && fallEv;
	end

	// captured values live in their own store
	capture_store uStore (
		.clk_sys              (clk_sys),
		.sys_rst              (sys_rst),
		.capWr                (capWr),
		.captureCompareAValue (captureCompareAValue),
		.captureBValue        (captureBValue)
	);

	// core next state
	always_comb begin
		stD     = stQ;
		stD.run = runNext;

		// counter: zero on start, hold while stopped, free-run otherwise
		if (runNext && !stQ.run) begin
			stD.cnt = `CNT_ZERO;
		end else if (stQ.run) begin
			if (periodMatch || (captureMode && edgeClr)) begin
				stD.cnt = `CNT_ZERO;
			end else begin
				stD.cnt = stQ.cnt + `CNT_ONE;
			end
		end

		// flag and level update one cycle after the latch edge
		stD.flagPend  = latchStrobe;
		stD.levelPend = riseEv;

		// software clears first so a same-cycle set still wins
		if (compareAFlagClr) begin
			stD.flags.compareAIrqFlag = 1'b0;
		end
		if (periodFlagClr) begin
			stD.flags.periodIrqFlag = 1'b0;
		end
		if (stQ.flagPend) begin
			stD.flags.compareAIrqFlag  = 1'b1;
			stD.flags.captureLevelFlag = stQ.levelPend;
		end
		if (stQ.run && periodMatch) begin
			stD.flags.periodIrqFlag = 1'b1;
		end

		// output only in single pulse; capture keeps the pin low
		stD.pulseOut = singlePulse && runNext;
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			stQ <= '0;
		end else begin
			stQ <= stD;
		end
	end

	// outputs straight from state
	assign timerRunBit  = stQ.run;
	assign counterValue = stQ.cnt;
	assign flags        = stQ.flags;
	assign timerIrq     = stQ.flags.compareAIrqFlag | stQ.flags.periodIrqFlag;
	assign timerOut     = stQ.pulseOut;

	// checks
	default clocking cbClk @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence sLatch;
		latchStrobe;
	endsequence

	sequence sFlagUp;
		##`FLAG_DELAY_CYCLES ##1 stQ.flags.compareAIrqFlag;
	endsequence

	a_capture_mode_gate: assert property (latchStrobe |-> ctrl.opMode == MODE_CAPTURE)
		else $error("capture latched outside capture mode");

	a_source_edge_seen: assert property (latchStrobe |-> srcPin != $past(srcPin))
		else $error("capture without a source pin transition");

	a_edge_none_quiet: assert property (
		ctrl.edgeOutputCtrl == EDGE_NONE |-> !latchStrobe)
		else $error("capture while edge field disables it");

	a_run_start_zero: assert property ($rose(stQ.run) |-> stQ.cnt == `CNT_ZERO)
		else $error("counter not zero at start");

	a_free_run_step: assert property (
		stQ.run && !periodMatch && !(captureMode && edgeClr) && !runWrEn
		|=> stQ.cnt == $past(stQ.cnt) + `CNT_ONE)
		else $error("counter did not advance");

	a_stop_hold: assert property (
		!stQ.run && !runNext |=> $stable(stQ.cnt))
		else $error("counter moved while stopped");

	a_latch_value: assert property (
		latchStrobe && !capWr.toB |=> captureCompareAValue == $past(stQ.cnt))
		else $error("register A missed the counter value");

	a_latch_b_value: assert property (
		latchStrobe && capWr.toB |=> captureBValue == $past(stQ.cnt))
		else $error("register B missed the counter value");

	a_flag_delay: assert property (sLatch |-> sFlagUp)
		else $error("compare A flag not set after latch");

	a_period_clear: assert property (
		stQ.run && periodMatch && !runWrEn
		|=> stQ.cnt == `CNT_ZERO && stQ.flags.periodIrqFlag)
		else $error("period match did not clear and flag");

	a_full_wrap: assert property (
		stQ.run && ctrl.periodCompareValue == `CNT_ZERO && stQ.cnt == `CNT_MAX && !runWrEn
		|=> stQ.cnt == `CNT_ZERO)
		else $error("counter did not wrap at maximum");

	a_edge_clear: assert property (
		stQ.run && captureMode && ctrl.captureClearSel == CLR_RISE && riseEv && !runWrEn
		|=> stQ.cnt == `CNT_ZERO)
		else $error("rising edge did not clear counter");

	a_sel00_to_a: assert property (
		latchStrobe && ctrl.captureClearSel == CLR_PERIOD |-> !capWr.toB)
		else $error("capture stored into B with clear field 00");

	a_fall_to_b: assert property (
		latchStrobe && ctrl.captureClearSel != CLR_PERIOD && fallEv |-> capWr.toB)
		else $error("falling capture not routed to B");

	a_no_output: assert property (captureMode |=> !timerOut)
		else $error("output driven in capture mode");

	a_ext_start: assert property (singlePulse && extRise |=> stQ.run)
		else $error("external edge did not start single pulse");

	a_period_flag_only: assert property (
		stQ.run && periodMatch && !stQ.flagPend && !stQ.flags.compareAIrqFlag
		|=> !stQ.flags.compareAIrqFlag)
		else $error("period match raised compare A flag");

	// software run writes; an external start in single pulse overrides a stop write
	a_run_write: assert property (runWrEn && runWrData |=> stQ.run)
		else $error("run write did not start the counter");

	a_run_stop: assert property (
		runWrEn && !runWrData && !(singlePulse && extRise) |=> !stQ.run)
		else $error("run write did not stop the counter");

	a_no_run_quiet: assert property (!stQ.run |-> !latchStrobe)
		else $error("capture while the counter is stopped");

	// the store may only move on a latch; a stray write would corrupt a measurement
	a_store_hold: assert property (
		!latchStrobe |=> $stable(captureCompareAValue) && $stable(captureBValue))
		else $error("capture register changed without a latch");

	a_both_edges: assert property (
		captureMode && stQ.run && ctrl.edgeOutputCtrl == EDGE_BOTH && (riseEv || fallEv)
		|-> latchStrobe)
		else $error("edge missed with both edges selected");

	a_fall_clear: assert property (
		stQ.run && captureMode && ctrl.captureClearSel == CLR_FALL && fallEv && !runWrEn
		|=> stQ.cnt == `CNT_ZERO)
		else $error("falling edge did not clear counter");

	a_both_clear: assert property (
		stQ.run && captureMode && ctrl.captureClearSel == CLR_BOTH && (riseEv || fallEv)
		&& !runWrEn |=> stQ.cnt == `CNT_ZERO)
		else $error("edge did not clear counter with both clears");

	a_rise_to_a: assert property (latchStrobe && riseEv |-> !capWr.toB)
		else $error("rising capture not routed to A");

	// level flag follows the direction of the latched edge, one flag delay later
	sequence sRiseLatch;
		latchStrobe && riseEv;
	endsequence

	sequence sFallLatch;
		latchStrobe && fallEv;
	endsequence

	sequence sLevelHigh;
		##`FLAG_DELAY_CYCLES ##1 stQ.flags.captureLevelFlag;
	endsequence

	sequence sLevelLow;
		##`FLAG_DELAY_CYCLES ##1 !stQ.flags.captureLevelFlag;
	endsequence

	a_level_rise: assert property (sRiseLatch |-> sLevelHigh)
		else $error("level flag not high after rising capture");

	a_level_fall: assert property (sFallLatch |-> sLevelLow)
		else $error("level flag not low after falling capture");

	// a clear with no pending set must take; a pending set wins instead
	a_flag_clear: assert property (
		compareAFlagClr && !stQ.flagPend |=> !stQ.flags.compareAIrqFlag)
		else $error("compare A flag survived its clear");

	a_period_flag_clr: assert property (
		periodFlagClr && !(stQ.run && periodMatch) |=> !stQ.flags.periodIrqFlag)
		else $error("period flag survived its clear");

	a_irq_follows: assert property (stQ.flagPend |=> timerIrq)
		else $error("no interrupt after a capture");

	a_pulse_level: assert property (singlePulse && runNext |=> timerOut)
		else $error("single pulse output not high while running");

endmodule : periodic_timer_capture_pulse

// ### tb/capture_source.sv
// model of the signal source that feeds the capture pins
`timescale 1ns/1ps
`include "timer_defines.svh"
module capture_source (
	// clock
	input  wire logic           clk_sys,
	// driven pins
	output logic [`SRC_N-1:0]   primaryCapturePin,
	output logic                extClockPin
);
	// pins start low so the first rise is a clean edge
	initial begin
		primaryCapturePin = '0;
		extClockPin       = 1'b0;
	end

	// move one pin at a rising edge; index 4 is the external pin
	// callers hold each level for at least two timer periods
	task automatic setPin(input int idx, input logic lvl);
		@(posedge clk_sys);
		if (idx == 4) begin
			extClockPin <= lvl;
		end
		else begin
			primaryCapturePin[idx] <= lvl;
		end
	endtask : setPin
endmodule : capture_source

// ### tb/periodic_timer_capture_pulse_tb.sv
// self-checking bench for the periodic timer capture block
`timescale 1ns/1ps
`include "timer_defines.svh"
module periodic_timer_capture_pulse_tb;
	import timer_pkg::*;

	logic                 clk_sys;
	logic                 sys_rst;
	ctrl_t                ctrl;
	logic                 runWrEn;
	logic                 runWrData;
	logic                 compareAFlagClr;
	logic                 periodFlagClr;
	logic [`SRC_N-1:0]    primaryCapturePin;
	logic                 extClockPin;
	logic                 timerRunBit;
	logic [`CNT_W-1:0]    counterValue;
	flags_t               flags;
	logic                 timerIrq;
	logic [`CNT_W-1:0]    captureCompareAValue;
	logic [`CNT_W-1:0]    captureBValue;
	logic                 timerOut;
	int                   n_errors;
	int                   num_checks;
	logic [`CNT_W-1:0]    expA;
	logic [`CNT_W-1:0]    expB;

	periodic_timer_capture_pulse u_periodic_timer_capture_pulse (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .ctrl(ctrl), .runWrEn(runWrEn),
		.runWrData(runWrData), .compareAFlagClr(compareAFlagClr),
		.periodFlagClr(periodFlagClr), .primaryCapturePin(primaryCapturePin),
		.extClockPin(extClockPin), .timerRunBit(timerRunBit), .counterValue(counterValue),
		.flags(flags), .timerIrq(timerIrq), .captureCompareAValue(captureCompareAValue),
		.captureBValue(captureBValue), .timerOut(timerOut));

	capture_source u_capture_source (
		.clk_sys(clk_sys), .primaryCapturePin(primaryCapturePin), .extClockPin(extClockPin));

	// 200 MHz timer clock
	initial clk_sys = 1'b0;
	always #2.5 clk_sys = ~clk_sys;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// sample 1 ns after the edge so the edge's updates have landed
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick

	task automatic runWrite(input logic v);
		@(posedge clk_sys);
		runWrEn   <= 1'b1;
		runWrData <= v;
		@(posedge clk_sys);
		runWrEn   <= 1'b0;
		#1;
	endtask : runWrite

	task automatic clrFlags();
		@(posedge clk_sys);
		compareAFlagClr <= 1'b1;
		periodFlagClr   <= 1'b1;
		@(posedge clk_sys);
		compareAFlagClr <= 1'b0;
		periodFlagClr   <= 1'b0;
		#1;
	endtask : clrFlags

	// period match at 5, stop holds the count, then the full range with period 0
	task automatic periodRun();
		ctrl.opMode             <= MODE_CAPTURE;
		ctrl.periodCompareValue <= 10'h005;
		clrFlags();
		runWrite(1'b1);
		tick(5);
		check(counterValue, 10'h005);
		check(flags.periodIrqFlag, 1'b0);
		tick(1);
		check(counterValue, 10'h000);
		check(flags.periodIrqFlag, 1'b1);
		check(flags.compareAIrqFlag, 1'b0);
		check(timerIrq, 1'b1);
		// the stop write lands two edges on and the counter still steps on both
		runWrite(1'b0);
		tick(3);
		check(counterValue, 10'h002);
		check(timerRunBit, 1'b0);
		ctrl.periodCompareValue <= 10'h000;
		clrFlags();
		check(flags.periodIrqFlag, 1'b0);
		check(timerIrq, 1'b0);
		check(counterValue, 10'h002);
		runWrite(1'b1);
		tick(1022);
		check(counterValue, 10'h3fe);
		tick(1);
		check(counterValue, 10'h3ff);
		check(flags.periodIrqFlag, 1'b0);
		tick(1);
		check(counterValue, 10'h000);
		check(flags.periodIrqFlag, 1'b1);
		runWrite(1'b0);
	endtask : periodRun

	// one rise then one fall on a chosen source, for one edge and clear setting;
	// lead-in and gap vary per call so a missed capture shows up as a stale value
	task automatic capCombo(input int e, input int c, input op_mode_t m);
		int                 src;
		int                 d;
		logic               rOn;
		logic               fOn;
		logic               capMode;
		logic [`CNT_W-1:0]  base;
		logic [`CNT_W-1:0]  fallVal;
		src     = (e * 4 + c) % 5;
		d       = 1 + e + c;
		capMode = (m == MODE_CAPTURE);
		rOn     = capMode && (e == 0 || e == 2);
		fOn     = capMode && (e == 1 || e == 2);
		// counter after the rise edge: cleared by a rise clear, else two past the lead-in
		base    = (capMode && c[0]) ? `CNT_ZERO : 10'(d + 2);
		fallVal = base + 10'(c + 2);
		ctrl.opMode              <= m;
		ctrl.edgeOutputCtrl      <= edge_sel_t'(e);
		ctrl.captureClearSel     <= clear_sel_t'(c);
		ctrl.inputSourceField    <= src[1:0];
		ctrl.captureSourceSelect <= (src == 4);
		clrFlags();
		runWrite(1'b1);
		tick(d);
		u_capture_source.setPin(src, 1'b1);
		tick(1);
		if (rOn) expA = 10'(d + 1);
		check(captureCompareAValue, expA);
		check(counterValue, base);
		tick(1);
		check(flags.compareAIrqFlag, rOn);
		check(timerIrq, rOn);
		check(timerOut, 1'b0);
		if (rOn && c != 0) check(flags.captureLevelFlag, 1'b1);
		tick(c);
		u_capture_source.setPin(src, 1'b0);
		compareAFlagClr <= 1'b1;
		tick(1);
		compareAFlagClr <= 1'b0;
		if (fOn && c == 0) expA = fallVal;
		if (fOn && c != 0) expB = fallVal;
		check(captureCompareAValue, expA);
		check(captureBValue, expB);
		check(counterValue, (capMode && c[1]) ? `CNT_ZERO : fallVal + `CNT_ONE);
		tick(1);
		check(flags.compareAIrqFlag, fOn);
		if (fOn && c != 0) check(flags.captureLevelFlag, 1'b0);
		runWrite(1'b0);
	endtask : capCombo

	// external pin rise starts the pulse, software ends it
	task automatic singlePulse();
		ctrl.opMode         <= MODE_PWM;
		ctrl.edgeOutputCtrl <= EDGE_NONE;
		u_capture_source.setPin(4, 1'b1);
		tick(1);
		check(timerRunBit, 1'b1);
		check(timerOut, 1'b1);
		runWrite(1'b0);
		check(timerOut, 1'b0);
		u_capture_source.setPin(4, 1'b0);
	endtask : singlePulse

	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end
		else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done

	// main sequence; the output-only control bits are set to show they do nothing
	initial begin
		n_errors        = 0;
		num_checks      = 0;
		expA            = '0;
		expB            = '0;
		sys_rst         = 1'b1;
		ctrl            = '0;
		ctrl.compareClearSelect = 1'b1;
		ctrl.outputInitialState = 1'b1;
		ctrl.outputPolarity     = 1'b1;
		runWrEn         = 1'b0;
		runWrData       = 1'b0;
		compareAFlagClr = 1'b0;
		periodFlagClr   = 1'b0;
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		tick(1);
		check({timerRunBit, counterValue, flags, timerOut}, '0);
		check({captureCompareAValue, captureBValue}, '0);
		periodRun();
		for (int e = 0; e < 4; e++) begin
			for (int c = 0; c < 4; c++) begin
				capCombo(e, c, MODE_CAPTURE);
			end
		end
		capCombo(0, 1, MODE_TIMER);
		singlePulse();
		test_done();
	end

	// the run needs about 1350 cycles; cut a hang well beyond that
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		test_done();
	end
endmodule : periodic_timer_capture_pulse_tb
